//--- design/mbcfg_pkg.sv
// Constants shared by the serial configuration register bank.
package mbcfg_pkg;
    // -----------------------------------------------------------------
    // Register offsets
    // -----------------------------------------------------------------
    localparam logic [15:0] REG_DEC4 = 16'h001B;
    localparam logic [15:0] REG_DEC5 = 16'h001C;
    localparam logic [15:0] REG_DEC6 = 16'h001D;
    localparam logic [15:0] REG_ADDR = 16'h0020;
    localparam logic [15:0] REG_IDENT = 16'h0021;
    localparam logic [15:0] REG_RATE = 16'h0022;
    localparam logic [15:0] REG_PERMIT = 16'h0023;
    localparam logic [15:0] REG_DELAY = 16'h0025;
    localparam logic [15:0] REG_ACK = 16'h0026;
    localparam logic [15:0] REG_GAP = 16'h0027;
    localparam logic [15:0] REG_LIGHT = 16'h002D;
    localparam logic [15:0] REG_HUE = 16'h002E;
    localparam logic [15:0] REG_EDIT = 16'h002F;
    localparam logic [15:0] REG_FORMAT = 16'h0030;
    localparam logic [15:0] REG_VLIGHT = 16'h0031;
    localparam logic [15:0] REG_VHUE = 16'h0032;
    // Value registers whose write acknowledge can be suppressed.
    localparam logic [15:0] REG_VALUE_LO = 16'h0001;
    localparam logic [15:0] REG_VALUE_HI = 16'h0003;
    // -----------------------------------------------------------------
    // Fields, functions and exception codes
    // -----------------------------------------------------------------
    localparam int BLINK_BIT = 12;
    localparam logic [7:0] FN_READ = 8'h03;
    localparam logic [7:0] FN_WRITE1 = 8'h06;
    localparam logic [7:0] FN_WRITEN = 8'h10;
    localparam logic [7:0] EXC_NONE = 8'h00;
    localparam logic [7:0] EXC_FUNC = 8'h01;
    localparam logic [7:0] EXC_ADDR = 8'h02;
    localparam logic [7:0] EXC_VALUE = 8'h03;
    localparam logic [7:0] EXC_DENIED = 8'h08;
    // -----------------------------------------------------------------
    // Ranges and values after reset
    // -----------------------------------------------------------------
    localparam logic [15:0] ADDR_MIN = 16'h0001;
    localparam logic [15:0] ADDR_MAX = 16'h00FF;
    localparam logic [15:0] RATE_MAX = 16'h0007;
    localparam logic [15:0] DELAY_MAX = 16'h0005;
    localparam logic [15:0] GAP_MAX = 16'h0063;
    localparam logic [15:0] LIGHT_MIN = 16'h0001;
    localparam logic [15:0] LIGHT_MAX = 16'h0008;
    localparam logic [15:0] FORMAT_MAX = 16'h0003;
    localparam logic [15:0] FLAG_MAX = 16'h0001;
    localparam logic [7:0] RST_ADDR = 8'h01;
    localparam logic [2:0] RST_RATE = 3'h3;
    localparam logic [3:0] RST_LIGHT = 4'h8;
    // -----------------------------------------------------------------
    // Timing
    // -----------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int BLINK_HALF_MS = 500;
    localparam int SECOND_MS = 1000;
    localparam int BLINK_HALF_CYCLES = CLK_HZ / 1000 * BLINK_HALF_MS;
    localparam int SECOND_CYCLES = CLK_HZ / 1000 * SECOND_MS;
    // Extra reply delay in character times for codes 1 to 5.
    localparam logic [7:0] DELAY_C1 = 8'h0A;
    localparam logic [7:0] DELAY_C2 = 8'h14;
    localparam logic [7:0] DELAY_C3 = 8'h32;
    localparam logic [7:0] DELAY_C4 = 8'h64;
    localparam logic [7:0] DELAY_C5 = 8'hC8;
endpackage

//--- design/mbcfg_regs.sv
// Serial configuration register bank of the slave display indicator.

module mbcfg_regs #(
    parameter bit SIX_DECADES = 1'b0,
    parameter logic [15:0] IDENT_FOUR = 16'h0A04,  // Arbitrary value.
    parameter logic [15:0] IDENT_SIX = 16'h0A06,  // Arbitrary value.
    parameter int BLINK_HALF = mbcfg_pkg::BLINK_HALF_CYCLES,
    parameter int SECOND = mbcfg_pkg::SECOND_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Decoded register request from the frame parser
    input wire logic req_valid,
    input wire logic [7:0] req_func,
    input wire logic [15:0] req_reg,
    input wire logic [15:0] req_wdata,
    input wire logic req_ext,
    input wire logic frame_seen,
    // Local menu access and mode pin
    input wire logic menu_we,
    input wire logic [15:0] menu_reg,
    input wire logic [15:0] menu_wdata,
    input wire logic slave_mode_pin,
    // Answer to the frame builder
    output logic rsp_valid,
    output logic [7:0] rsp_exc,
    output logic [15:0] rsp_rdata,
    output logic rsp_quiet,
    output logic [7:0] rsp_addr,
    output logic [2:0] rsp_baud,
    // Settings seen by the rest of the device
    output logic [7:0] slave_address,
    output logic [2:0] baud_code,
    output logic write_permit,
    output logic [7:0] reply_delay,
    output logic gap_expired,
    output logic [3:0] light_level,
    output logic led_hue,
    output logic edit_style,
    output logic [1:0] value_format,
    output logic [2:0] decade_dark
);
    // -----------------------------------------------------------------
    // Storage
    // -----------------------------------------------------------------
    logic [15:0] attr [3];
    logic [2:0] delay_code;
    logic ack_enable;
    logic [6:0] gap_limit;
    logic [3:0] stored_light;
    logic stored_hue;
    logic [3:0] vol_light;
    logic vol_hue;
    logic light_ovr;
    logic hue_ovr;
    logic mode_meta;
    logic mode_sync;
    logic [25:0] blink_cnt;
    logic blink_phase;
    logic [25:0] sec_cnt;
    logic [6:0] gap_secs;

    // -----------------------------------------------------------------
    // Request decode
    // -----------------------------------------------------------------
    // Register existence; the upper decades vanish on the four-decade build.
    function automatic logic exists(input logic [15:0] r);
        exists = (r == mbcfg_pkg::REG_DEC4) || (r == mbcfg_pkg::REG_ADDR)
            || (r == mbcfg_pkg::REG_IDENT) || (r == mbcfg_pkg::REG_RATE)
            || (r == mbcfg_pkg::REG_PERMIT) || (r == mbcfg_pkg::REG_DELAY)
            || (r == mbcfg_pkg::REG_ACK) || (r == mbcfg_pkg::REG_GAP)
            || ((r >= mbcfg_pkg::REG_LIGHT) && (r <= mbcfg_pkg::REG_VHUE))
            || (SIX_DECADES && ((r == mbcfg_pkg::REG_DEC5)
            || (r == mbcfg_pkg::REG_DEC6)));
    endfunction

    // Permitted write range of each register.
    function automatic logic in_range(input logic [15:0] r, input logic [15:0] v);
        case (r)
            mbcfg_pkg::REG_ADDR: in_range = (v >= mbcfg_pkg::ADDR_MIN)
                && (v <= mbcfg_pkg::ADDR_MAX);
            mbcfg_pkg::REG_RATE: in_range = v <= mbcfg_pkg::RATE_MAX;
            mbcfg_pkg::REG_DELAY: in_range = v <= mbcfg_pkg::DELAY_MAX;
            mbcfg_pkg::REG_GAP: in_range = v <= mbcfg_pkg::GAP_MAX;
            mbcfg_pkg::REG_LIGHT, mbcfg_pkg::REG_VLIGHT: in_range =
                (v >= mbcfg_pkg::LIGHT_MIN) && (v <= mbcfg_pkg::LIGHT_MAX);
            mbcfg_pkg::REG_FORMAT: in_range = v <= mbcfg_pkg::FORMAT_MAX;
            mbcfg_pkg::REG_DEC4, mbcfg_pkg::REG_DEC5, mbcfg_pkg::REG_DEC6: in_range = 1'b1;
            mbcfg_pkg::REG_IDENT: in_range = 1'b0;
            default: in_range = v <= mbcfg_pkg::FLAG_MAX;
        endcase
    endfunction

    // Exception selection, function first, then address, permission, value.
    wire is_read = req_func == mbcfg_pkg::FN_READ;
    wire is_write = (req_func == mbcfg_pkg::FN_WRITE1) || (req_func == mbcfg_pkg::FN_WRITEN);
    wire own_hit = exists(req_reg);
    wire ro_write = is_write && (req_reg == mbcfg_pkg::REG_IDENT);
    wire value_ok = req_ext || in_range(req_reg, req_wdata);
    // Read data is only returned for an accepted read of a register of this bank.
    wire rd_ok;
    wire [7:0] next_exc =
        !(is_read || is_write) ? mbcfg_pkg::EXC_FUNC :
        (!req_ext && (!own_hit || ro_write)) ? mbcfg_pkg::EXC_ADDR :
        (is_write && !write_permit) ? mbcfg_pkg::EXC_DENIED :
        (is_write && !value_ok) ? mbcfg_pkg::EXC_VALUE :
        mbcfg_pkg::EXC_NONE;
    wire wr_ok = req_valid && is_write && !req_ext && (next_exc == mbcfg_pkg::EXC_NONE);
    assign rd_ok = is_read && !req_ext && (next_exc == mbcfg_pkg::EXC_NONE);
    wire menu_ok = menu_we && exists(menu_reg) && in_range(menu_reg, menu_wdata);
    wire [15:0] wr_reg = wr_ok ? req_reg : menu_reg;
    wire [15:0] wr_val = wr_ok ? req_wdata : menu_wdata;
    wire wr_any = wr_ok || menu_ok;
    // Acknowledge suppression covers the value registers held in another bank.
    wire next_quiet = is_write && !ack_enable && (req_reg >= mbcfg_pkg::REG_VALUE_LO)
        && (req_reg <= mbcfg_pkg::REG_VALUE_HI);

    // Read data multiplexer.
    wire [15:0] ident = SIX_DECADES ? IDENT_SIX : IDENT_FOUR;
    logic [15:0] next_rdata;
    always_comb begin
        case (req_reg)
            mbcfg_pkg::REG_DEC4: next_rdata = attr[0];
            mbcfg_pkg::REG_DEC5: next_rdata = attr[1];
            mbcfg_pkg::REG_DEC6: next_rdata = attr[2];
            mbcfg_pkg::REG_ADDR: next_rdata = {8'h00, slave_address};
            mbcfg_pkg::REG_IDENT: next_rdata = ident;
            mbcfg_pkg::REG_RATE: next_rdata = {13'h0000, baud_code};
            mbcfg_pkg::REG_PERMIT: next_rdata = {15'h0000, write_permit};
            mbcfg_pkg::REG_DELAY: next_rdata = {13'h0000, delay_code};
            mbcfg_pkg::REG_ACK: next_rdata = {15'h0000, ack_enable};
            mbcfg_pkg::REG_GAP: next_rdata = {9'h000, gap_limit};
            mbcfg_pkg::REG_LIGHT: next_rdata = {12'h000, stored_light};
            mbcfg_pkg::REG_HUE: next_rdata = {15'h0000, stored_hue};
            mbcfg_pkg::REG_EDIT: next_rdata = {15'h0000, edit_style};
            mbcfg_pkg::REG_FORMAT: next_rdata = {14'h0000, value_format};
            mbcfg_pkg::REG_VLIGHT: next_rdata = {12'h000, vol_light};
            mbcfg_pkg::REG_VHUE: next_rdata = {15'h0000, vol_hue};
            default: next_rdata = 16'h0000;
        endcase
    end

    // -----------------------------------------------------------------
    // Answer register
    // -----------------------------------------------------------------
    // The address is caught before the write lands so the reply carries the old one,
    // while the baud code is taken after so the reply goes out at the new rate.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid <= 1'b0;
            rsp_exc <= 8'h00;
            rsp_rdata <= 16'h0000;
            rsp_quiet <= 1'b0;
            rsp_addr <= 8'h00;
        end else begin
            rsp_valid <= req_valid;
            rsp_exc <= next_exc;
            rsp_rdata <= rd_ok ? next_rdata : 16'h0000;
            rsp_quiet <= next_quiet && (next_exc == mbcfg_pkg::EXC_NONE);
            rsp_addr <= slave_address;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_baud <= mbcfg_pkg::RST_RATE;
        end else if (wr_any && wr_reg == mbcfg_pkg::REG_RATE) begin
            rsp_baud <= wr_val[2:0];
        end else begin
            rsp_baud <= baud_code;
        end
    end

    // -----------------------------------------------------------------
    // Setting registers
    // -----------------------------------------------------------------
    // Serial and menu writes share one port; a serial write wins a collision.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            slave_address <= mbcfg_pkg::RST_ADDR;
            baud_code <= mbcfg_pkg::RST_RATE;
            delay_code <= 3'h0;
            ack_enable <= 1'b1;
            gap_limit <= 7'h00;
            stored_light <= mbcfg_pkg::RST_LIGHT;
            stored_hue <= 1'b0;
            edit_style <= 1'b0;
            value_format <= 2'h0;
        end else if (wr_any) begin
            case (wr_reg)
                mbcfg_pkg::REG_ADDR: slave_address <= wr_val[7:0];
                mbcfg_pkg::REG_RATE: baud_code <= wr_val[2:0];
                mbcfg_pkg::REG_DELAY: delay_code <= wr_val[2:0];
                mbcfg_pkg::REG_ACK: ack_enable <= wr_val[0];
                mbcfg_pkg::REG_GAP: gap_limit <= wr_val[6:0];
                mbcfg_pkg::REG_LIGHT: stored_light <= wr_val[3:0];
                mbcfg_pkg::REG_HUE: stored_hue <= wr_val[0];
                mbcfg_pkg::REG_EDIT: edit_style <= wr_val[0];
                mbcfg_pkg::REG_FORMAT: value_format <= wr_val[1:0];
                default: ;
            endcase
        end
    end

    // Write permission: the serial path can only lower it, the menu sets it freely.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            write_permit <= 1'b1;
        end else if (menu_ok && !wr_ok && menu_reg == mbcfg_pkg::REG_PERMIT) begin
            write_permit <= menu_wdata[0];
        end else if (wr_ok && req_reg == mbcfg_pkg::REG_PERMIT) begin
            write_permit <= write_permit & req_wdata[0];
        end
    end

    // Decade attributes, one word per decade.
    genvar d;
    generate
        for (d = 0; d < 3; d++) begin : g_attr
            always_ff @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    attr[d] <= 16'h0000;
                end else if (wr_any && wr_reg == mbcfg_pkg::REG_DEC4 + 16'(d)) begin
                    attr[d] <= wr_val;
                end
            end
        end
    endgenerate

    // Overrides are volatile: reset drops them so stored values rule again,
    // and a later write to a stored value hands control back to it.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vol_light <= mbcfg_pkg::RST_LIGHT;
            vol_hue <= 1'b0;
            light_ovr <= 1'b0;
            hue_ovr <= 1'b0;
        end else if (wr_any) begin
            if (wr_reg == mbcfg_pkg::REG_VLIGHT) begin
                vol_light <= wr_val[3:0];
                light_ovr <= 1'b1;
            end
            if (wr_reg == mbcfg_pkg::REG_VHUE) begin
                vol_hue <= wr_val[0];
                hue_ovr <= 1'b1;
            end
            if (wr_reg == mbcfg_pkg::REG_LIGHT) begin
                light_ovr <= 1'b0;
            end
            if (wr_reg == mbcfg_pkg::REG_HUE) begin
                hue_ovr <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // Derived outputs
    // -----------------------------------------------------------------
    logic [7:0] next_delay;
    always_comb begin
        case (delay_code)
            3'h1: next_delay = mbcfg_pkg::DELAY_C1;
            3'h2: next_delay = mbcfg_pkg::DELAY_C2;
            3'h3: next_delay = mbcfg_pkg::DELAY_C3;
            3'h4: next_delay = mbcfg_pkg::DELAY_C4;
            3'h5: next_delay = mbcfg_pkg::DELAY_C5;
            default: next_delay = 8'h00;
        endcase
    end
    wire [2:0] next_dark = {attr[2][mbcfg_pkg::BLINK_BIT], attr[1][mbcfg_pkg::BLINK_BIT],
        attr[0][mbcfg_pkg::BLINK_BIT]} & {3{blink_phase && mode_sync}};
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reply_delay <= 8'h00;
            light_level <= mbcfg_pkg::RST_LIGHT;
            led_hue <= 1'b0;
            decade_dark <= 3'h0;
        end else begin
            reply_delay <= next_delay;
            light_level <= light_ovr ? vol_light : stored_light;
            led_hue <= hue_ovr ? vol_hue : stored_hue;
            decade_dark <= next_dark;
        end
    end

    // Mode pin comes from outside the clock domain.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_meta <= 1'b0;
            mode_sync <= 1'b0;
        end else begin
            mode_meta <= slave_mode_pin;
            mode_sync <= mode_meta;
        end
    end

    // Half-second blink phase, giving a one hertz flash.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            blink_cnt <= 26'h0000000;
            blink_phase <= 1'b0;
        end else if (blink_cnt == 26'(BLINK_HALF - 1)) begin
            blink_cnt <= 26'h0000000;
            blink_phase <= !blink_phase;
        end else begin
            blink_cnt <= blink_cnt + 26'h0000001;
        end
    end

    // Frame gap watch: whole seconds since the last frame; saturates at 127.
    wire sec_tick = sec_cnt == 26'(SECOND - 1);
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sec_cnt <= 26'h0000000;
            gap_secs <= 7'h00;
            gap_expired <= 1'b0;
        end else if (frame_seen) begin
            sec_cnt <= 26'h0000000;
            gap_secs <= 7'h00;
            gap_expired <= 1'b0;
        end else begin
            sec_cnt <= sec_tick ? 26'h0000000 : sec_cnt + 26'h0000001;
            if (sec_tick && gap_secs != 7'h7F) begin
                gap_secs <= gap_secs + 7'h01;
            end
            gap_expired <= (gap_limit != 7'h00) && (gap_secs >= gap_limit);
        end
    end

    // -----------------------------------------------------------------
    // Checks
    // -----------------------------------------------------------------
    old_address_a: assert property (@(posedge clk) disable iff (!reset_n)
        req_valid |=> rsp_valid && rsp_addr == $past(slave_address))
        else $error("reply address is not the previous one");
    new_rate_a: assert property (@(posedge clk) disable iff (!reset_n)
        rsp_valid |-> rsp_baud == baud_code)
        else $error("reply rate differs from selected rate");
    bad_function_a: assert property (@(posedge clk) disable iff (!reset_n)
        req_valid && !(is_read || is_write) |=> rsp_exc == 8'h01)
        else $error("unsupported function not refused");
    bad_address_a: assert property (@(posedge clk) disable iff (!reset_n)
        req_valid && is_read && !req_ext && !own_hit |=> rsp_exc == 8'h02 && rsp_rdata == 0)
        else $error("missing register not refused");
    write_denied_a: assert property (@(posedge clk) disable iff (!reset_n)
        req_valid && is_write && own_hit && !ro_write && !write_permit && !menu_we
        |=> rsp_exc == 8'h08 && $stable(slave_address) && $stable(baud_code))
        else $error("denied write not refused or applied");
    bad_value_a: assert property (@(posedge clk) disable iff (!reset_n)
        req_valid && is_write && write_permit && !req_ext && req_reg == mbcfg_pkg::REG_LIGHT
        && req_wdata == 16'h0000 && !menu_we |=> rsp_exc == 8'h03 && $stable(stored_light))
        else $error("brightness zero accepted");
    permit_sticky_a: assert property (@(posedge clk) disable iff (!reset_n)
        !write_permit && !menu_we |=> !write_permit)
        else $error("serial link raised write permission");
    ack_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
        req_valid && req_func == 8'h06 && req_reg == 16'h0002 && req_ext && write_permit
        && !ack_enable |=> rsp_quiet)
        else $error("value write acknowledged while blocked");
    override_a: assert property (@(posedge clk) disable iff (!reset_n)
        wr_ok && req_reg == mbcfg_pkg::REG_VLIGHT |=> ##1 light_level == $past(req_wdata[3:0], 2))
        else $error("brightness override not applied");
    blink_mode_a: assert property (@(posedge clk) disable iff (!reset_n)
        !mode_sync |=> decade_dark == 3'h0)
        else $error("decade blinks outside slave mode");
    gap_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        gap_limit == 7'h00 |=> !gap_expired)
        else $error("gap check active while disabled");
endmodule

//--- testbench/mbcfg_master_model.sv
// Bus master model that hands decoded register requests to the bank.
module mbcfg_master_model (
    // Clock
    input wire logic clk,
    // Request to the bank
    output logic req_valid,
    output logic [7:0] req_func,
    output logic [15:0] req_reg,
    output logic [15:0] req_wdata,
    output logic req_ext
);
    timeunit 1ns;
    timeprecision 1ps;
    initial {req_valid, req_ext, req_func, req_reg, req_wdata} = '0;
    // One request pulse; function, register and data are inverted afterwards so stale values are never trusted.
    task automatic send(input logic [7:0] f, input logic [15:0] r, w, input logic x);
        @(posedge clk);
        req_valid <= 1'b1;
        req_func <= f;
        req_reg <= r;
        req_wdata <= w;
        req_ext <= x;
        @(posedge clk);
        req_valid <= 1'b0;
        req_func <= ~f;
        req_reg <= ~r;
        req_wdata <= ~w;
    endtask
endmodule

//--- testbench/tb_mbcfg_regs.sv
// Self-checking bench for the serial configuration register bank.
module tb_mbcfg_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset_n = 1'b0, menu_we = 1'b0, frame_seen = 1'b0, mode_pin = 1'b1;
    logic req_valid, req_ext;
    logic [15:0] menu_reg = 16'h0023, menu_wdata = 16'h0001, req_reg, req_wdata, rsp_rdata;
    logic [7:0] req_func, rsp_exc, rsp_addr, slave_address, reply_delay;
    logic rsp_valid, rsp_quiet, write_permit, gap_expired, led_hue, edit_style;
    logic [2:0] rsp_baud, baud_code, decade_dark;
    logic [3:0] light_level;
    logic [1:0] value_format;
    int err_total = 0, checked = 0, hits = 0;
    // Short timers keep the run brief; the ident value is arbitrary.
    mbcfg_regs #(.IDENT_FOUR(16'h0B44), .BLINK_HALF(8), .SECOND(16)) mbcfg_regs_inst (.clk,
        .reset_n, .req_valid, .req_func, .req_reg, .req_wdata, .req_ext, .frame_seen,
        .menu_we, .menu_reg, .menu_wdata, .slave_mode_pin(mode_pin), .rsp_valid, .rsp_exc,
        .rsp_rdata, .rsp_quiet, .rsp_addr, .rsp_baud, .slave_address, .baud_code,
        .write_permit, .reply_delay, .gap_expired, .light_level, .led_hue, .edit_style,
        .value_format, .decade_dark);
    mbcfg_master_model mbcfg_master_model_inst (.clk, .req_valid, .req_func, .req_reg,
        .req_wdata, .req_ext);
    initial forever #10 clk = ~clk;
    task automatic chk(input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // The answer stands for one cycle only, so it is sampled just after the taking edge.
    task automatic rq(input logic [7:0] f, input logic [15:0] r, w, input logic x,
        input logic [7:0] e);
        mbcfg_master_model_inst.send(f, r, w, x);
        #1;
        chk(16'(rsp_valid), 16'h0001);
        chk(16'(rsp_exc), 16'(e));
    endtask
    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        chk(16'(slave_address), 16'h0001);
        chk(16'(baud_code), 16'h0003);
        chk(16'(light_level), 16'h0008);
        rq(8'h03, 16'h0021, 16'h0000, 1'b0, 8'h00);
        chk(rsp_rdata, 16'h0B44);
        rq(8'h06, 16'h0021, 16'h0001, 1'b0, 8'h02);
        rq(8'h04, 16'h0020, 16'h0002, 1'b0, 8'h01);
        rq(8'h03, 16'h0024, 16'h0000, 1'b0, 8'h02);
        rq(8'h03, 16'h001C, 16'h0000, 1'b0, 8'h02);
        rq(8'h10, 16'h001B, 16'h1000, 1'b0, 8'h00);
        rq(8'h03, 16'h001B, 16'h0000, 1'b0, 8'h00);
        chk(rsp_rdata, 16'h1000);
        // Blink period is two half periods of 8 cycles, so any 16 samples see 8 dark ones.
        repeat (16) begin
            @(posedge clk);
            #1;
            hits += (decade_dark == 3'h1);
        end
        chk(16'(hits), 16'h0008);
        @(posedge clk);
        mode_pin <= 1'b0;
        hits = 0;
        repeat (3) @(posedge clk);
        repeat (16) begin
            @(posedge clk);
            #1;
            hits += (decade_dark != 3'h0);
        end
        chk(16'(hits), 16'h0000);
        rq(8'h06, 16'h0020, 16'h0000, 1'b0, 8'h03);
        rq(8'h06, 16'h0020, 16'h0002, 1'b0, 8'h00);
        chk(16'(rsp_addr), 16'h0001);
        chk(16'(slave_address), 16'h0002);
        rq(8'h06, 16'h0022, 16'h0008, 1'b0, 8'h03);
        rq(8'h06, 16'h0022, 16'h0005, 1'b0, 8'h00);
        chk(16'(rsp_baud), 16'h0005);
        rq(8'h06, 16'h0025, 16'h0004, 1'b0, 8'h00);
        @(posedge clk);
        #1;
        chk(16'(reply_delay), 16'h0064);
        rq(8'h06, 16'h0031, 16'h0003, 1'b0, 8'h00);
        @(posedge clk);
        #1;
        chk(16'(light_level), 16'h0003);
        rq(8'h06, 16'h0026, 16'h0000, 1'b0, 8'h00);
        rq(8'h06, 16'h0002, 16'h0010, 1'b1, 8'h00);
        chk(16'(rsp_quiet), 16'h0001);
        rq(8'h06, 16'h002D, 16'h0000, 1'b0, 8'h03);
        rq(8'h06, 16'h002F, 16'h0001, 1'b0, 8'h00);
        chk(16'(edit_style), 16'h0001);
        rq(8'h06, 16'h0030, 16'h0004, 1'b0, 8'h03);
        rq(8'h06, 16'h0030, 16'h0003, 1'b0, 8'h00);
        chk(16'(value_format), 16'h0003);
        rq(8'h06, 16'h0032, 16'h0001, 1'b0, 8'h00);
        @(posedge clk);
        #1;
        chk(16'(led_hue), 16'h0001);
        rq(8'h06, 16'h002E, 16'h0000, 1'b0, 8'h00);
        @(posedge clk);
        #1;
        chk(16'(led_hue), 16'h0000);
        // Gap limit of one second, which is 16 cycles with the short timer.
        rq(8'h06, 16'h0027, 16'h0064, 1'b0, 8'h03);
        rq(8'h06, 16'h0027, 16'h0001, 1'b0, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        chk(16'(gap_expired), 16'h0001);
        @(posedge clk);
        frame_seen <= 1'b1;
        @(posedge clk);
        frame_seen <= 1'b0;
        #1;
        chk(16'(gap_expired), 16'h0000);
        repeat (16) @(posedge clk);
        #1;
        chk(16'(gap_expired), 16'h0000);
        @(posedge clk);
        #1;
        chk(16'(gap_expired), 16'h0001);
        rq(8'h06, 16'h0023, 16'h0000, 1'b0, 8'h00);
        rq(8'h06, 16'h0023, 16'h0001, 1'b0, 8'h08);
        chk(16'(write_permit), 16'h0000);
        @(posedge clk);
        menu_we <= 1'b1;
        @(posedge clk);
        menu_we <= 1'b0;
        @(posedge clk);
        #1;
        chk(16'(write_permit), 16'h0001);
        tally_and_finish();
    end
endmodule
